/* File: design/lcdpc_pkg.sv */
package lcdpc_pkg;
  // register map, 4-bit word address
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h1;

  // pin geometry
  localparam int ROWS = 4;
  localparam int COLS = 32;
  localparam int GROUP_PINS = 4;
  localparam int NUM_GROUPS = COLS / GROUP_PINS;
  localparam int TOP_GROUP = NUM_GROUPS - 1;

  // duty field codes
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;

  // row pins driven per duty when common expand is clear
  localparam logic [3:0] ROWS_STATIC = 4'h1;
  localparam logic [3:0] ROWS_HALF = 4'h3;
  localparam logic [3:0] ROWS_THIRD = 4'h7;
  localparam logic [3:0] ROWS_ALL = 4'hf;

  // segment group field values that keep the top group as ports
  localparam logic [3:0] SGS_ALL_PORT = 4'h0;

  // control register layout, msb first: duty(7:6), common_expand(5), expansion_select(4), group select(3:0)
  typedef struct packed {
    logic [1:0] duty_sel;
    logic common_expand;
    logic expansion_select;
    logic [3:0] segment_group_select;
  } lcdpc_ctrl_s;

  localparam lcdpc_ctrl_s CTRL_RESET = 8'h00;

  // external expansion signals, in pin order 32 down to 29
  typedef struct packed {
    logic shift_pulse_a;
    logic shift_pulse_b;
    logic serial_out;
    logic alt_signal;
  } lcdpc_exp_s;
endpackage

/* File: design/lcdpc_group.sv */
`timescale 1ns/1ns
// one group of four column pins: port, segment driver or expansion signals
module lcdpc_group #(
  parameter int GROUP = 0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire lcdpc_pkg::lcdpc_ctrl_s i_cfg,
  input wire logic [3:0] i_seg_wave,
  input wire logic [3:0] i_port_out,
  input wire logic [3:0] i_port_oe,
  input wire lcdpc_pkg::lcdpc_exp_s i_exp,
  output logic [3:0] o_out,
  output logic [3:0] o_oe,
  output logic o_is_seg
);
  import lcdpc_pkg::*;

  logic is_seg;
  logic is_exp;
  logic [2:0] span;

  // groups counted from the top: 1, 2 or 3 steps give 2, 4 or 6 groups
  always_comb begin
    span = {1'b0, i_cfg.segment_group_select[2:1]} << 1;
    is_seg = i_cfg.segment_group_select[3] ||
             ((span != 3'h0) && (GROUP >= NUM_GROUPS - int'(span)));
    // expansion only in the one legal combination; other codes with the select set fall back to the table
    is_exp = (GROUP == TOP_GROUP) && i_cfg.expansion_select &&
             (i_cfg.segment_group_select == SGS_ALL_PORT);
  end

  // registered pin drive, so every pin changes on a clean edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out <= 4'h0;
      o_oe <= 4'h0;
      o_is_seg <= 1'b0;
    end else if (is_exp) begin
      o_out <= i_exp;
      o_oe <= 4'hf;
      o_is_seg <= 1'b0;
    end else if (is_seg) begin
      o_out <= i_seg_wave;
      o_oe <= 4'hf;
      o_is_seg <= 1'b1;
    end else begin
      o_out <= i_port_out;
      o_oe <= i_port_oe;
      o_is_seg <= 1'b0;
    end
  end
endmodule

/* File: design/lcdpc_top.sv */
`timescale 1ns/1ns
// How it works
// - the duty field selects static, 1/2, 1/3 or 1/4 duty, driving one to four row pins when common expand is clear.
// - static duty with common expand set drives all four row pins with the waveform of row pin one.
// - half duty with common expand set drives four rows, row four copying row three and row two copying row one.
// - third duty with common expand set drives rows three to one normally and row four with the non-selected wave.
// - with expansion select clear the group field gives all ports, top 8, 16, 24 segments, or all segments.
// - expansion select turns column pins 32 to 29 into the expansion signals; software keeps the group field at zero.
// - group field 0001, or 0000 with expansion select clear, leaves the top four column pins as general ports.
module lcdpc_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [lcdpc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lcdpc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [lcdpc_pkg::ROWS-1:0] i_row_wave,
  input wire logic i_nonsel_wave,
  input wire logic [lcdpc_pkg::COLS-1:0] i_seg_wave,
  input wire logic [lcdpc_pkg::COLS-1:0] i_port_out,
  input wire logic [lcdpc_pkg::COLS-1:0] i_port_oe,
  input wire lcdpc_pkg::lcdpc_exp_s i_exp,
  output logic [lcdpc_pkg::DATA_W-1:0] o_rd_data,
  output logic [lcdpc_pkg::ROWS-1:0] o_row_out,
  output logic [lcdpc_pkg::ROWS-1:0] o_row_oe,
  output logic [lcdpc_pkg::COLS-1:0] o_col_out,
  output logic [lcdpc_pkg::COLS-1:0] o_col_oe,
  output logic [lcdpc_pkg::COLS-1:0] o_col_is_seg
);
  import lcdpc_pkg::*;

  lcdpc_ctrl_s cfg_reg;
  logic [3:0] row_en_next;
  logic [3:0] row_out_next;
  logic cfg_bad;
  logic exp_active;
  logic [DATA_W-1:0] status;
  logic [NUM_GROUPS-1:0] grp_seg;

  // control register; every bit starts clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= CTRL_RESET;
    end else if (i_wr_en && (i_addr == ADDR_CTRL)) begin
      cfg_reg <= i_wr_data;
    end
  end

  // read data holds only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en && (i_addr == ADDR_CTRL)) begin
      o_rd_data <= cfg_reg;
    end else if (i_rd_en && (i_addr == ADDR_STAT)) begin
      o_rd_data <= status;
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // status: prohibited group code under expansion, expansion live, rows enabled
  always_comb begin
    cfg_bad = cfg_reg.expansion_select && (cfg_reg.segment_group_select != SGS_ALL_PORT);
    exp_active = cfg_reg.expansion_select && !cfg_bad;
    status = {2'h0, cfg_bad, exp_active, row_en_next};
  end

  // row pin selection and waveform routing
  always_comb begin
    row_out_next = i_row_wave;
    case (cfg_reg.duty_sel)
      DUTY_STATIC: begin
        row_en_next = ROWS_STATIC;
        if (cfg_reg.common_expand) begin
          row_en_next = ROWS_ALL;
          row_out_next = {4{i_row_wave[0]}};
        end
      end
      DUTY_HALF: begin
        row_en_next = ROWS_HALF;
        if (cfg_reg.common_expand) begin
          row_en_next = ROWS_ALL;
          // second phase moves to row three so each phase drives a pair
          row_out_next = {{2{i_row_wave[1]}}, {2{i_row_wave[0]}}};
        end
      end
      DUTY_THIRD: begin
        row_en_next = ROWS_THIRD;
        if (cfg_reg.common_expand) begin
          row_en_next = ROWS_ALL;
          row_out_next = {i_nonsel_wave, i_row_wave[2:0]};
        end
      end
      DUTY_QUARTER: begin
        row_en_next = ROWS_ALL;
      end
      default: begin
        row_en_next = ROWS_STATIC;
      end
    endcase
  end

  // undriven rows idle low with the driver off
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_row_out <= 4'h0;
      o_row_oe <= 4'h0;
    end else begin
      o_row_out <= row_out_next & row_en_next;
      o_row_oe <= row_en_next;
    end
  end

  // eight column groups; only the top group reacts to expansion
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_col
    lcdpc_group #(.GROUP(g)) u_group (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_cfg(cfg_reg),
      .i_seg_wave(i_seg_wave[g*GROUP_PINS +: GROUP_PINS]),
      .i_port_out(i_port_out[g*GROUP_PINS +: GROUP_PINS]),
      .i_port_oe(i_port_oe[g*GROUP_PINS +: GROUP_PINS]),
      .i_exp(i_exp),
      .o_out(o_col_out[g*GROUP_PINS +: GROUP_PINS]),
      .o_oe(o_col_oe[g*GROUP_PINS +: GROUP_PINS]),
      .o_is_seg(grp_seg[g])
    );
    assign o_col_is_seg[g*GROUP_PINS +: GROUP_PINS] = {GROUP_PINS{grp_seg[g]}};
  end

  // checks: outputs lag the configuration by one edge
  // the edge after release still shows reset values, so checks that look back wait for a clean previous edge
  a_row_enable_count: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(!cfg_reg.common_expand) |->
      o_row_oe == (($past(cfg_reg.duty_sel) == DUTY_STATIC) ? 4'h1 :
                   ($past(cfg_reg.duty_sel) == DUTY_HALF) ? 4'h3 :
                   ($past(cfg_reg.duty_sel) == DUTY_THIRD) ? 4'h7 : 4'hf))
    else $error("row enables do not match duty");

  a_static_row_mirror: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($past(cfg_reg.duty_sel) == DUTY_STATIC) && $past(cfg_reg.common_expand) |->
      (o_row_oe == 4'hf) && (o_row_out == {4{$past(i_row_wave[0])}}))
    else $error("static expanded rows do not mirror row one");

  a_half_row_pairs: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($past(cfg_reg.duty_sel) == DUTY_HALF) && $past(cfg_reg.common_expand) |->
      (o_row_oe == 4'hf) && (o_row_out[3] == o_row_out[2]) && (o_row_out[1] == o_row_out[0]) &&
      (o_row_out[0] == $past(i_row_wave[0])))
    else $error("half duty expanded rows not paired");

  a_third_row_nonsel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($past(cfg_reg.duty_sel) == DUTY_THIRD) && $past(cfg_reg.common_expand) |->
      (o_row_out == {$past(i_nonsel_wave), $past(i_row_wave[2:0])}) && (o_row_oe == 4'hf))
    else $error("third duty row four not non-selected");

  a_seg_group_map: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(!cfg_reg.expansion_select) |->
      o_col_is_seg == ($past(cfg_reg.segment_group_select[3]) ? 32'hffffffff :
                       ($past(cfg_reg.segment_group_select[2:1]) == 2'h1) ? 32'hff000000 :
                       ($past(cfg_reg.segment_group_select[2:1]) == 2'h2) ? 32'hffff0000 :
                       ($past(cfg_reg.segment_group_select[2:1]) == 2'h3) ? 32'hffffff00 : 32'h00000000))
    else $error("segment group map wrong");

  a_expansion_pins: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(cfg_reg.expansion_select) && ($past(cfg_reg.segment_group_select) == SGS_ALL_PORT) |->
      (o_col_out[31:28] == $past(i_exp)) && (o_col_oe[31:28] == 4'hf) && (o_col_is_seg == 32'h0))
    else $error("expansion pins not routed");

  a_top_group_port: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && ($past(cfg_reg.segment_group_select[3:1]) == 3'h0) && !$past(exp_active) |->
      (o_col_out[31:28] == $past(i_port_out[31:28])) && (o_col_oe[31:28] == $past(i_port_oe[31:28])))
    else $error("top pins not ports");

  a_reset_config_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$past(i_rst_n) |-> (cfg_reg == CTRL_RESET) && (o_row_oe == 4'h0) && (o_col_is_seg == 32'h0))
    else $error("configuration not clear after reset");

  // a row that is not enabled must read low, so an idle electrode never sees a stale level
  a_rows_off_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_row_out & ~o_row_oe) == 4'h0)
    else $error("disabled row pin not low");

  // without common expand every enabled row passes its own waveform straight through
  a_row_wave_pass: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && !$past(cfg_reg.common_expand) |->
      o_row_out == ($past(i_row_wave) & o_row_oe))
    else $error("row waveform not passed through");

  // quarter duty already uses every row, so common expand changes nothing there
  a_quarter_rows: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && ($past(cfg_reg.duty_sel) == DUTY_QUARTER) |->
      (o_row_oe == 4'hf) && (o_row_out == $past(i_row_wave)))
    else $error("quarter duty rows wrong");

  // half duty pairs: the upper pair must carry the second phase, not a copy of the first
  a_half_row_upper: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && ($past(cfg_reg.duty_sel) == DUTY_HALF) && $past(cfg_reg.common_expand) |->
      o_row_out[3:2] == {2{$past(i_row_wave[1])}})
    else $error("half duty upper rows not on second phase");

  // segment pins always drive, and each drives the segment waveform of its own pin
  a_seg_pins_drive: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) |->
      ((o_col_oe & o_col_is_seg) == o_col_is_seg) &&
      ((o_col_out & o_col_is_seg) == ($past(i_seg_wave) & o_col_is_seg)))
    else $error("segment pin not driving its waveform");

  // below the top group a pin that is not a segment is a plain port, whatever expansion does
  a_low_ports_follow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) |->
      (((o_col_out[27:0] ^ $past(i_port_out[27:0])) & ~o_col_is_seg[27:0]) == 28'h0) &&
      (((o_col_oe[27:0] ^ $past(i_port_oe[27:0])) & ~o_col_is_seg[27:0]) == 28'h0))
    else $error("low port pins not following port inputs");

  // codes 0000 and 0001 never hand any column to the segment drivers
  a_low_codes_no_seg: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && ($past(cfg_reg.segment_group_select[3:1]) == 3'h0) |->
      o_col_is_seg == 32'h0)
    else $error("segment pins under an all-port code");

  // a group field left nonzero under expansion is reported, not blocked; software must fix it
  a_status_prohibited: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd_en) && ($past(i_addr) == ADDR_STAT) |->
      o_rd_data[5:4] == {$past(cfg_reg.expansion_select) && ($past(cfg_reg.segment_group_select) != SGS_ALL_PORT),
                         $past(cfg_reg.expansion_select) && ($past(cfg_reg.segment_group_select) == SGS_ALL_PORT)})
    else $error("status expansion flags wrong");
endmodule

/* File: verif/lcdpc_panel.sv */
`timescale 1ns/1ns
// panel side: counts the row electrodes the block actively drives
module lcdpc_panel (
  input wire logic i_clock,
  input wire logic [3:0] i_row_oe,
  output logic [2:0] o_rows_on
);
  // sampled on the edge, the glass only ever sees settled levels
  always_ff @(posedge i_clock) begin
    o_rows_on <= 3'($countones(i_row_oe));
  end
endmodule

/* File: verif/lcd_port_duty_config_bench.sv */
`timescale 1ns/1ns
// random sweep of every control value, with reset and read-back corners
module lcd_port_duty_config_bench;
  import lcdpc_pkg::*;
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_wr_en = 1'h0;
  logic i_rd_en = 1'h0;
  logic i_nonsel_wave = 1'h0;
  logic [3:0] i_addr = 4'h0;
  logic [3:0] i_row_wave = 4'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic [31:0] i_seg_wave = 32'h0, i_port_out = 32'h0, i_port_oe = 32'h0;
  lcdpc_exp_s i_exp = 4'h0;
  logic [7:0] o_rd_data, st;
  logic [3:0] o_row_out, o_row_oe;
  logic [31:0] o_col_out, o_col_oe, o_col_is_seg;
  logic [2:0] rows_on;
  logic [103:0] e;
  logic [31:0] seed = 32'h00002b6c;
  lcdpc_ctrl_s c;
  int err_count = 0;
  int n_tests = 0;
  wire logic [103:0] pins = {o_row_out, o_row_oe, o_col_out, o_col_oe, o_col_is_seg};

  lcdpc_top uut (.i_clock, .i_rst_n, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .i_row_wave, .i_nonsel_wave,
    .i_seg_wave, .i_port_out, .i_port_oe, .i_exp, .o_rd_data, .o_row_out, .o_row_oe, .o_col_out, .o_col_oe,
    .o_col_is_seg);
  lcdpc_panel panel (.i_clock, .i_row_oe(o_row_oe), .o_rows_on(rows_on));

  // clock
  initial begin
    forever #4 i_clock = ~i_clock;
  end

  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected pin state from the control value and the present inputs
  function automatic logic [103:0] exp_pins(lcdpc_ctrl_s k);
    logic [3:0] ro, oe;
    logic [31:0] co, ce, cs;
    int n;
    oe = k.common_expand ? 4'hf : ((4'h2 << k.duty_sel) - 4'h1);
    ro = i_row_wave & oe;
    if (k.common_expand) begin
      case (k.duty_sel)
        2'h0: ro = {4{i_row_wave[0]}};
        2'h1: ro = {i_row_wave[1], i_row_wave[1], i_row_wave[0], i_row_wave[0]};
        2'h2: ro = {i_nonsel_wave, i_row_wave[2:0]};
        default: ro = i_row_wave;
      endcase
    end
    n = k.segment_group_select[3] ? 8 : 2 * int'(k.segment_group_select[2:1]);
    for (int g = 0; g < 8; g++) begin
      cs[4*g+:4] = (g >= 8 - n) ? 4'hf : 4'h0;
      co[4*g+:4] = cs[4*g] ? i_seg_wave[4*g+:4] : i_port_out[4*g+:4];
      ce[4*g+:4] = cs[4*g] ? 4'hf : i_port_oe[4*g+:4];
    end
    // expansion only takes the top group with an all-zero group field
    if (k.expansion_select && k.segment_group_select == 4'h0) begin
      co[31:28] = i_exp;
      ce[31:28] = 4'hf;
    end
    return {ro, oe, co, ce, cs};
  endfunction

  task automatic chk(input logic [103:0] got, input logic [103:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one strobe cycle, write when w is high, read otherwise
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_en <= w;
    i_rd_en <= ~w;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_en <= 1'h0;
    i_rd_en <= 1'h0;
  endtask

  // read data must stand in exactly one cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    bus(1'h0, a, 8'h00);
    #1 chk(104'(o_rd_data), 104'(x), "read data");
    @(posedge i_clock);
    #1 chk(104'(o_rd_data), 104'h0, "read data held over");
  endtask

  task automatic rst();
    @(posedge i_clock);
    i_rst_n <= 1'h0;
    repeat (6) @(posedge i_clock);
    #1 chk(pins, 104'h0, "pins during reset");
    @(posedge i_clock);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_clock);
    #1 chk(pins, exp_pins(8'h00), "pins after reset");
    rd(ADDR_CTRL, 8'h00);
  endtask

  // watchdog sized well beyond the sweep length
  initial begin
    #80000;
    err_count++;
    end_of_test();
  end

  initial begin
    rst();
    $display("reset test done");
    for (int i = 0; i < 320; i++) begin
      c = (i < 256) ? 8'(i) : 8'(rnd());
      @(posedge i_clock);
      i_row_wave <= 4'(rnd());
      i_nonsel_wave <= 1'(rnd());
      i_seg_wave <= rnd();
      i_port_out <= rnd();
      i_port_oe <= rnd();
      i_exp <= 4'(rnd());
      bus(1'h1, ADDR_CTRL, c);
      @(posedge i_clock);
      #1 chk(pins, exp_pins(c), "pin functions");
      e = exp_pins(c);
      st = {2'h0, c.expansion_select && c.segment_group_select != 4'h0, 1'h0, e[99:96]};
      st[4] = c.expansion_select && c.segment_group_select == 4'h0;
      rd(ADDR_CTRL, c);
      rd(ADDR_STAT, st);
      bus(1'h1, ADDR_STAT, 8'(rnd()));
      rd(ADDR_CTRL, c);
      chk(104'(rows_on), 104'($countones(e[99:96])), "panel row count");
    end
    rd(4'h9, 8'h00);
    $display("sweep test done");
    rst();
    $display("mid reset test done");
    end_of_test();
  end
endmodule
